// ==== ifcd_classify.sv ====
// ifcd_classify: combinational sort of an opcode into category and form
// assumes the opcode is the upper byte of a program word
`timescale 1ns/1ns
`default_nettype none
module ifcd_classify
  import ifcd_pkg::*;
(
  input  wire logic [7:0] opcode_i,
  output logic      [2:0] category_o,
  output logic            two_word_o,
  output logic            is_nop_o,
  output logic            is_mac_o,
  output logic            is_mem_o,
  output logic            fixed_multi_o,
  output logic            cond_o,
  output logic            skip_o
);

  function automatic logic in_range(input logic [7:0] v,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  wire logic w_ctl = in_range(opcode_i, IFCD_CTL_LO, IFCD_CTL_HI);
  wire logic w_lit = in_range(opcode_i, IFCD_LIT_LO, IFCD_LIT_HI);
  wire logic w_bit = in_range(opcode_i, IFCD_BIT_LO, IFCD_BIT_HI);
  wire logic w_dsp = in_range(opcode_i, IFCD_DSP_LO, IFCD_DSP_HI);

  // all-zero opcode falls into control as a no-operation
  assign category_o = w_ctl || (opcode_i == IFCD_OPC_NOP)
                        ? 3'(IFCD_CAT_CONTROL)
                    : w_lit ? 3'(IFCD_CAT_LITERAL)
                    : w_bit ? 3'(IFCD_CAT_BIT)
                    : w_dsp ? 3'(IFCD_CAT_DSP)
                    : 3'(IFCD_CAT_WORD_BYTE);
  assign two_word_o = (opcode_i == IFCD_OPC_CALL2)
                   || (opcode_i == IFCD_OPC_JUMP2)
                   || (opcode_i == IFCD_OPC_MOVD2);
  assign is_nop_o   = (opcode_i == IFCD_OPC_NOP);
  assign is_mac_o   = in_range(opcode_i, IFCD_OPC_MAC_LO, IFCD_OPC_MAC_HI);
  assign is_mem_o   = in_range(opcode_i, IFCD_MEM_LO, IFCD_MEM_HI);
  assign fixed_multi_o = (opcode_i == IFCD_OPC_JREL)
                      || (opcode_i == IFCD_OPC_JIND)
                      || (opcode_i == IFCD_OPC_RET)
                      || (opcode_i == IFCD_OPC_RETI)
                      || (opcode_i == IFCD_OPC_TBLRD)
                      || (opcode_i == IFCD_OPC_TBLWR);
  assign cond_o = (opcode_i == IFCD_OPC_CJREL);
  assign skip_o = (opcode_i == IFCD_OPC_SKIP)
               || (opcode_i == IFCD_OPC_BSKIP);

endmodule // ifcd_classify
`default_nettype wire

// ==== ifcd_decoder.sv ====
// ifcd_decoder: instruction format, operand and cycle decoder
// assumes program memory offers one 24-bit word per cycle with a valid flag
// and that the core takes a taken-condition and a skip result as inputs
`timescale 1ns/1ns
`default_nettype none
module ifcd_decoder
  import ifcd_pkg::*;
#(
  parameter int WORD_W = IFCD_WORD_W
)(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic [WORD_W-1:0] fetch_word_i,
  input  wire logic              fetch_valid_i,
  input  wire logic              cond_true_i,
  input  wire logic              skip_taken_i,
  output logic                   dec_valid_o,
  output logic [7:0]             opcode_o,
  output logic [2:0]             category_o,
  output logic                   two_word_o,
  output logic [47:0]            span_o,
  output logic                   nop_o,
  output logic                   flush_o,
  output logic [1:0]             cycles_o,
  output logic [3:0]             base_source_reg_o,
  output logic [3:0]             second_source_reg_o,
  output logic [3:0]             result_dest_reg_o,
  output logic [2:0]             src_mode_o,
  output logic [2:0]             dst_mode_o,
  output logic                   dst_present_o,
  output logic [15:0]            literal_o,
  output logic                   bit_indirect_o,
  output logic                   acc_b_o,
  output logic [3:0]             x_prefetch_o,
  output logic [3:0]             y_prefetch_o,
  output logic [1:0]             x_pf_dest_o,
  output logic [1:0]             y_pf_dest_o,
  output logic [1:0]             acc_wb_o,
  output logic [3:0]             shift_count_register_o,
  output logic                   shift_by_reg_o,
  output logic [22:0]            prog_addr_o,
  output logic [2:0]             table_mode_o,
  output logic                   format_err_o
);

  // ------------------------------------------------------------------
  // sequencing state
  // ------------------------------------------------------------------
  typedef enum {
    IFCD_ST_FIRST,
    IFCD_ST_SECOND,
    IFCD_ST_STALL
  } ifcd_state_t;

  ifcd_state_t state_r, state_nxt;
  logic [WORD_W-1:0] first_r;
  logic [1:0]        stall_r, stall_nxt;
  logic              skip_pend_r, skip_pend_nxt;

  // ------------------------------------------------------------------
  // opcode and classification
  // ------------------------------------------------------------------
  wire logic [7:0] w_opc = fetch_word_i[IFCD_OPC_MSB:IFCD_OPC_LSB];
  wire logic [2:0] w_cat;
  wire logic       w_two, w_nop, w_mac, w_mem, w_fixed, w_cond, w_skip;

  ifcd_classify u_cls (
    .opcode_i      (w_opc),
    .category_o    (w_cat),
    .two_word_o    (w_two),
    .is_nop_o      (w_nop),
    .is_mac_o      (w_mac),
    .is_mem_o      (w_mem),
    .fixed_multi_o (w_fixed),
    .cond_o        (w_cond),
    .skip_o        (w_skip)
  );

  // classification of the held first word, for the second-word cycle
  wire logic [7:0] w_hopc = first_r[IFCD_OPC_MSB:IFCD_OPC_LSB];
  wire logic       w_hmem;

  ifcd_classify u_hcls (
    .opcode_i      (w_hopc),
    .category_o    (),
    .two_word_o    (),
    .is_nop_o      (),
    .is_mac_o      (),
    .is_mem_o      (w_hmem),
    .fixed_multi_o (),
    .cond_o        (),
    .skip_o        ()
  );

  wire logic [3:0]  w_s1, w_s2, w_d;
  wire logic [2:0]  w_sm, w_dm;
  wire logic [15:0] w_lit;
  wire logic        w_accb;

  ifcd_fields u_fld (
    .word_i     (fetch_word_i),
    .is_mem_i   (w_mem),
    .src1_o     (w_s1),
    .src2_o     (w_s2),
    .dst_o      (w_d),
    .src_mode_o (w_sm),
    .dst_mode_o (w_dm),
    .lit_o      (w_lit),
    .acc_b_o    (w_accb),
    .to_mem_o   ()
  );

  // ------------------------------------------------------------------
  // qualifying the incoming word
  // ------------------------------------------------------------------
  wire logic w_first   = (state_r == IFCD_ST_FIRST);
  wire logic w_second  = (state_r == IFCD_ST_SECOND);
  wire logic w_take    = fetch_valid_i && w_first && !skip_pend_r;
  wire logic w_start2  = w_take && w_two;
  wire logic w_single  = w_take && !w_two;
  // a second word fetched in the first-word slot decodes as a no-op
  wire logic w_as_nop  = w_take && w_nop;
  wire logic w_join    = fetch_valid_i && w_second;
  // top byte of a second word must be zero
  wire logic w_bad2    = w_join
                      && (fetch_word_i[IFCD_OPC_MSB:IFCD_OPC_LSB]
                          != IFCD_OPC_NOP);
  // skipped word is consumed without effect; its size sets the cost
  wire logic w_skipped = fetch_valid_i && w_first && skip_pend_r;

  wire logic w_cat_dsp = (w_cat == 3'(IFCD_CAT_DSP));
  wire logic w_cat_bit = (w_cat == 3'(IFCD_CAT_BIT));
  wire logic w_cat_lit = (w_cat == 3'(IFCD_CAT_LITERAL));
  wire logic w_cat_ctl = (w_cat == 3'(IFCD_CAT_CONTROL));
  wire logic w_cat_wb  = (w_cat == 3'(IFCD_CAT_WORD_BYTE));

  // ------------------------------------------------------------------
  // cycle count
  // ------------------------------------------------------------------
  function automatic logic [1:0] cyc_of(input logic fixed_m,
                                        input logic cond,
                                        input logic ctrue,
                                        input logic skp,
                                        input logic stak);
    if (fixed_m) begin
      cyc_of = IFCD_CYC_TWO;
    end else if ((cond && ctrue) || (skp && stak)) begin
      cyc_of = IFCD_CYC_TWO;
    end else begin
      cyc_of = IFCD_CYC_ONE;
    end
  endfunction

  wire logic [1:0] w_cyc1 = cyc_of(w_fixed, w_cond, cond_true_i,
                                   w_skip, skip_taken_i);
  // flow change: fixed multi-cycle or conditional jump with a true condition
  wire logic w_flow = w_single && (w_fixed || (w_cond && cond_true_i));
  wire logic w_skip_go = w_single && w_skip && skip_taken_i;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    stall_nxt     = stall_r;
    skip_pend_nxt = skip_pend_r;
    case (state_r)
      IFCD_ST_FIRST: begin
        if (w_skipped) begin
          skip_pend_nxt = 1'b0;
          // a two-word victim needs its second word swallowed too
          if (w_two) begin
            state_nxt = IFCD_ST_STALL;
            stall_nxt = 2'h1;
          end
        end else if (w_start2) begin
          state_nxt = IFCD_ST_SECOND;
        end else if (w_skip_go) begin
          skip_pend_nxt = 1'b1;
        end else if (w_flow) begin
          state_nxt = IFCD_ST_STALL;
          stall_nxt = 2'h1;
        end
      end
      IFCD_ST_SECOND: begin
        if (fetch_valid_i) begin
          state_nxt = (w_hopc == IFCD_OPC_CALL2 || w_hopc == IFCD_OPC_JUMP2)
                    ? IFCD_ST_STALL : IFCD_ST_FIRST;
          stall_nxt = 2'h1;
        end
      end
      IFCD_ST_STALL: begin
        // one word behind the flow change is dropped, not decoded
        if (fetch_valid_i || stall_r == 2'h0) begin
          state_nxt = IFCD_ST_FIRST;
          stall_nxt = 2'h0;
        end
      end
      default: begin
        state_nxt = IFCD_ST_FIRST;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r     <= IFCD_ST_FIRST;
      stall_r     <= 2'h0;
      skip_pend_r <= 1'b0;
      first_r     <= '0;
    end else begin
      state_r     <= state_nxt;
      stall_r     <= stall_nxt;
      skip_pend_r <= skip_pend_nxt;
      if (w_start2) begin
        first_r <= fetch_word_i;
      end
    end
  end

  // ------------------------------------------------------------------
  // decoded outputs, registered one cycle after the word is accepted
  // ------------------------------------------------------------------
  wire logic w_out = w_single || w_join;
  wire logic w_issue_nop = w_as_nop || w_skipped
                        || (fetch_valid_i && state_r == IFCD_ST_STALL);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dec_valid_o  <= 1'b0;
      nop_o        <= 1'b0;
      flush_o      <= 1'b0;
      format_err_o <= 1'b0;
    end else begin
      dec_valid_o  <= w_out || w_issue_nop;
      nop_o        <= w_issue_nop || (w_join && w_bad2);
      flush_o      <= w_flow || w_skip_go
                   || (w_join && (w_hopc == IFCD_OPC_CALL2
                                  || w_hopc == IFCD_OPC_JUMP2));
      format_err_o <= w_bad2;
    end
  end

  // field holding registers: the two-word form takes its opcode
  // from the held first word and its extension from the second
  wire logic [47:0] w_span = w_join ? {first_r, fetch_word_i}
                                    : {fetch_word_i, 24'h000000};
  wire logic [7:0]  w_opc_o = w_join ? w_hopc : w_opc;
  wire logic [1:0]  w_cyc_o = w_join ? IFCD_CYC_TWO : w_cyc1;
  wire logic [2:0]  w_cat_o = w_join ? 3'(IFCD_CAT_CONTROL) : w_cat;
  // literal arithmetic encodes a destination only when it differs
  wire logic w_dpres = w_cat_lit ? (w_d != w_s1) : !w_cat_ctl;
  // target bit indirect from base register when the flag is set
  wire logic w_bitind = w_cat_bit && fetch_word_i[IFCD_BITIND_BIT];
  wire logic w_shreg  = w_cat_dsp && !w_mac && !fetch_word_i[IFCD_DIR_BIT];
  // program address for control: low 16 bits zero-extended to 23; join the two words
  wire logic [22:0] w_paddr = w_join
    ? {fetch_word_i[6:0], first_r[15:0]}
    : {7'h00, w_lit};

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      opcode_o               <= 8'h00;
      category_o             <= 3'(IFCD_CAT_CONTROL);
      two_word_o             <= 1'b0;
      span_o                 <= 48'h000000000000;
      cycles_o               <= IFCD_CYC_ONE;
      base_source_reg_o      <= 4'h0;
      second_source_reg_o    <= 4'h0;
      result_dest_reg_o      <= 4'h0;
      src_mode_o             <= 3'h0;
      dst_mode_o             <= 3'h0;
      dst_present_o          <= 1'b0;
      literal_o              <= 16'h0000;
      bit_indirect_o         <= 1'b0;
      acc_b_o                <= 1'b0;
      x_prefetch_o           <= 4'h0;
      y_prefetch_o           <= 4'h0;
      x_pf_dest_o            <= 2'h0;
      y_pf_dest_o            <= 2'h0;
      acc_wb_o               <= 2'h0;
      shift_count_register_o <= 4'h0;
      shift_by_reg_o         <= 1'b0;
      prog_addr_o            <= 23'h000000;
      table_mode_o           <= 3'h0;
    end else if (w_out) begin
      opcode_o               <= w_opc_o;
      category_o             <= w_cat_o;
      two_word_o             <= w_join;
      span_o                 <= w_span;
      cycles_o               <= w_cyc_o;
      base_source_reg_o      <= w_s1;
      second_source_reg_o    <= w_s2;
      result_dest_reg_o      <= (w_join && w_hmem) ? IFCD_DEFAULT_WORKING_REGISTER_IDX : w_d;
      src_mode_o             <= w_sm;
      dst_mode_o             <= (w_cat_wb && w_mem) ? 3'h0 : w_dm;
      dst_present_o          <= w_dpres;
      literal_o              <= w_lit;
      bit_indirect_o         <= w_bitind;
      acc_b_o                <= w_accb;
      x_prefetch_o           <= w_mac ? w_lit[IFCD_XPF_LSB +: IFCD_PF_W]
                                      : 4'h0;
      y_prefetch_o           <= w_mac ? w_lit[IFCD_YPF_LSB +: IFCD_PF_W]
                                      : 4'h0;
      x_pf_dest_o            <= w_mac ? w_lit[IFCD_XD_LSB +: IFCD_PFD_W]
                                      : 2'h0;
      y_pf_dest_o            <= w_mac ? w_lit[IFCD_YD_LSB +: IFCD_PFD_W]
                                      : 2'h0;
      acc_wb_o               <= w_mac ? w_lit[IFCD_AWB_LSB +: IFCD_AWB_W]
                                      : 2'h0;
      shift_count_register_o <= w_s2;
      shift_by_reg_o         <= w_shreg;
      prog_addr_o            <= w_paddr;
      table_mode_o           <= w_cat_ctl ? w_sm : 3'h0;
    end
  end

endmodule // ifcd_decoder
`default_nettype wire

// ==== ifcd_decoder_monitor.sv ====
// ifcd_decoder_monitor: concurrent checks on the decoder ports
// assumes binding into every ifcd_decoder instance
`timescale 1ns/1ns
`default_nettype none
module ifcd_decoder_monitor
  import ifcd_pkg::*;
#(
  parameter int WORD_W = IFCD_WORD_W
)(
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        dec_valid_o,
  input wire logic [7:0]  opcode_o,
  input wire logic [2:0]  category_o,
  input wire logic        two_word_o,
  input wire logic [47:0] span_o,
  input wire logic        nop_o,
  input wire logic        flush_o,
  input wire logic [1:0]  cycles_o,
  input wire logic [3:0]  result_dest_reg_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // nop slots carry no meaningful fields, so most checks skip them
  wire ok = dec_valid_o && !nop_o;
  wire dw = opcode_o inside {IFCD_OPC_CALL2, IFCD_OPC_JUMP2, IFCD_OPC_MOVD2};
  AST_LIT_ONE: assert property (ok && opcode_o[7:4] == 4'h2 |->
    cycles_o == IFCD_CYC_ONE && category_o == 3'h2) else $error("lit op");
  AST_DW_SET: assert property (ok && dw |-> two_word_o)
    else $error("two-word opcode not flagged");
  AST_DW_ONLY: assert property (dec_valid_o && two_word_o |->
    dw && cycles_o == IFCD_CYC_TWO) else $error("two-word form wrong");
  AST_SPAN_ONE: assert property (ok && !two_word_o |->
    span_o == {opcode_o, span_o[39:24], 24'h0}) else $error("single span");
  AST_SPAN_TWO: assert property (ok && two_word_o |->
    span_o[23:16] == 8'h00 && span_o[47:40] == opcode_o) else $error("span");
  AST_ZERO_NOP: assert property (dec_valid_o
    && opcode_o == IFCD_OPC_NOP |-> nop_o)
    else $error("zero opcode not a no-op");
  AST_JUMP_FLUSH: assert property (ok && opcode_o == IFCD_OPC_JUMP2
    |-> flush_o) else $error("jump without flush");
  AST_MEM_W0: assert property (ok && opcode_o[7:4] == 4'hB
    && !span_o[37] |-> result_dest_reg_o == IFCD_DEFAULT_WORKING_REGISTER_IDX)
    else $error("memory dest not W0");
  cover property (ok && two_word_o);
  cover property (flush_o);
  cover property (dec_valid_o && nop_o);
endmodule // ifcd_decoder_monitor
bind ifcd_decoder ifcd_decoder_monitor #(.WORD_W(WORD_W))
  ifcd_decoder_monitor_inst
  (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .dec_valid_o(dec_valid_o),
   .opcode_o(opcode_o), .category_o(category_o), .two_word_o(two_word_o),
   .span_o(span_o), .nop_o(nop_o), .flush_o(flush_o), .cycles_o(cycles_o),
   .result_dest_reg_o(result_dest_reg_o));
`default_nettype wire

// ==== ifcd_fields.sv ====
// ifcd_fields: combinational extraction of operand fields from a word
// assumes the category has already been decided by the caller
`timescale 1ns/1ns
`default_nettype none
module ifcd_fields
  import ifcd_pkg::*;
(
  input  wire logic [23:0] word_i,
  input  wire logic        is_mem_i,
  output logic      [3:0]  src1_o,
  output logic      [3:0]  src2_o,
  output logic      [3:0]  dst_o,
  output logic      [2:0]  src_mode_o,
  output logic      [2:0]  dst_mode_o,
  output logic      [15:0] lit_o,
  output logic             acc_b_o,
  output logic             to_mem_o
);

  // register selectors are always four bits: W0 to W15
  assign src1_o     = word_i[IFCD_BASE_LSB +: IFCD_REG_W];
  assign src2_o     = word_i[IFCD_SRC_LSB  +: IFCD_REG_W];
  // memory forms with the direction bit clear default the destination to the working register W0
  assign to_mem_o   = word_i[IFCD_DIR_BIT];
  assign dst_o      = (is_mem_i && !to_mem_o) ? IFCD_DEFAULT_WORKING_REGISTER_IDX
                    : word_i[IFCD_DST_LSB +: IFCD_REG_W];
  assign src_mode_o = word_i[IFCD_SMODE_LSB +: IFCD_MODE_W];
  assign dst_mode_o = word_i[IFCD_DMODE_LSB +: IFCD_MODE_W];
  assign lit_o      = word_i[IFCD_FIELD_W-1:0];
  assign acc_b_o    = word_i[IFCD_ACC_BIT];

endmodule // ifcd_fields
`default_nettype wire

// ==== ifcd_pkg.sv ====
// ifcd_pkg: constants and types for the instruction format and cycle decoder
// assumes a 24-bit program word and sixteen working registers
package ifcd_pkg;

  // ------------------------------------------------------------------
  // word layout
  // ------------------------------------------------------------------
  localparam int IFCD_WORD_W     = 24;
  localparam int IFCD_OPC_W      = 8;
  localparam int IFCD_OPC_MSB    = 23;
  localparam int IFCD_OPC_LSB    = 16;
  localparam int IFCD_REG_W      = 4;
  localparam int IFCD_FIELD_W    = 16;
  localparam int IFCD_SPAN_W     = 48;
  localparam int IFCD_MODE_W     = 3;
  localparam int IFCD_CYC_W      = 2;

  // operand field positions within a word
  localparam int IFCD_DST_LSB    = 7;
  localparam int IFCD_BASE_LSB   = 11;
  localparam int IFCD_SRC_LSB    = 0;
  localparam int IFCD_SMODE_LSB  = 4;
  localparam int IFCD_DMODE_LSB  = 11;
  localparam int IFCD_ACC_BIT    = 15;
  localparam int IFCD_DIR_BIT    = 13;
  localparam int IFCD_BITIND_BIT = 15;
  localparam int IFCD_XPF_LSB    = 2;
  localparam int IFCD_YPF_LSB    = 6;
  localparam int IFCD_PF_W       = 4;
  localparam int IFCD_XD_LSB     = 12;
  localparam int IFCD_YD_LSB     = 10;
  localparam int IFCD_PFD_W      = 2;
  localparam int IFCD_AWB_LSB    = 0;
  localparam int IFCD_AWB_W      = 2;
  localparam int IFCD_MACOP_LSB  = 10;
  localparam int IFCD_MACOP_W    = 4;

  // opcode ranges of the five categories
  localparam logic [7:0] IFCD_OPC_NOP     = 8'h00;
  localparam logic [7:0] IFCD_CTL_LO      = 8'h01;
  localparam logic [7:0] IFCD_CTL_HI      = 8'h0F;
  localparam logic [7:0] IFCD_LIT_LO      = 8'h20;
  localparam logic [7:0] IFCD_LIT_HI      = 8'h2F;
  localparam logic [7:0] IFCD_BIT_LO      = 8'hA0;
  localparam logic [7:0] IFCD_BIT_HI      = 8'hAF;
  localparam logic [7:0] IFCD_DSP_LO      = 8'hC0;
  localparam logic [7:0] IFCD_DSP_HI      = 8'hCF;
  localparam logic [7:0] IFCD_MEM_LO      = 8'hB0;
  localparam logic [7:0] IFCD_MEM_HI      = 8'hBF;

  // the three two-word opcodes
  localparam logic [7:0] IFCD_OPC_CALL2   = 8'h02;
  localparam logic [7:0] IFCD_OPC_JUMP2   = 8'h04;
  localparam logic [7:0] IFCD_OPC_MOVD2   = 8'h08;

  // other opcodes with multi-cycle timing, and the MAC opcode range
  localparam logic [7:0] IFCD_OPC_JREL    = 8'h03;
  localparam logic [7:0] IFCD_OPC_JIND    = 8'h01;
  localparam logic [7:0] IFCD_OPC_RET     = 8'h06;
  localparam logic [7:0] IFCD_OPC_RETI    = 8'h07;
  localparam logic [7:0] IFCD_OPC_TBLRD   = 8'h0A;
  localparam logic [7:0] IFCD_OPC_TBLWR   = 8'h0B;
  localparam logic [7:0] IFCD_OPC_CJREL   = 8'h05;
  localparam logic [7:0] IFCD_OPC_SKIP    = 8'h0C;
  localparam logic [7:0] IFCD_OPC_BSKIP   = 8'hAE;
  localparam logic [7:0] IFCD_OPC_MAC_LO  = 8'hC0;
  localparam logic [7:0] IFCD_OPC_MAC_HI  = 8'hC7;

  // cycle figures
  localparam logic [1:0] IFCD_CYC_ONE     = 2'h1;
  localparam logic [1:0] IFCD_CYC_TWO     = 2'h2;
  localparam logic [1:0] IFCD_CYC_THREE   = 2'h3;

  // default working register
  localparam logic [3:0] IFCD_DEFAULT_WORKING_REGISTER_IDX    = 4'h0;

  typedef enum {
    IFCD_CAT_WORD_BYTE,
    IFCD_CAT_BIT,
    IFCD_CAT_LITERAL,
    IFCD_CAT_DSP,
    IFCD_CAT_CONTROL
  } ifcd_cat_t;

endpackage : ifcd_pkg

// ==== ifcd_pmem_model.sv ====
// ifcd_pmem_model: program memory side, one word per put call
// assumes the caller sits at or after a falling clock edge
`timescale 1ns/1ns
`default_nettype none
module ifcd_pmem_model (
  input  wire logic        sys_clk_i,
  output logic      [23:0] fetch_word_o,
  output logic             fetch_valid_o
);
  initial begin
    fetch_word_o = 24'h0;
    fetch_valid_o = 1'b0;
  end
  // released bus shows the inverse so stale data never passes as valid
  task automatic put(input logic [23:0] w);
    @(negedge sys_clk_i);
    fetch_word_o = w;
    fetch_valid_o = 1'b1;
    @(negedge sys_clk_i);
    fetch_valid_o = 1'b0;
    fetch_word_o = ~w;
  endtask
endmodule // ifcd_pmem_model
`default_nettype wire

// ==== instruction_format_cycle_decoder_tb.sv ====
// instruction_format_cycle_decoder_tb: self-checking decoder bench
// assumes ifcd_pkg, the decoder and the memory model are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,a) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %0h got %0h", n, e, a); end end
module instruction_format_cycle_decoder_tb;
  import ifcd_pkg::*;
  logic sys_clk_i = 1'b0, rst_i = 1'b1;
  logic cond_true_i = 1'b0, skip_taken_i = 1'b0;
  logic bit_indirect_o, acc_b_o, shift_by_reg_o, format_err_o;
  logic [2:0] src_mode_o;
  logic [3:0] x_prefetch_o;
  logic [23:0] fetch_word_i, w, w2;
  logic fetch_valid_i, dec_valid_o, two_word_o, nop_o, flush_o, dst_present_o;
  logic [7:0] opcode_o;
  logic [2:0] category_o;
  logic [47:0] span_o;
  logic [1:0] cycles_o;
  logic [3:0] base_source_reg_o, second_source_reg_o, result_dest_reg_o;
  logic [15:0] literal_o;
  logic [22:0] prog_addr_o;
  logic [7:0] dwop [3] = '{IFCD_OPC_CALL2, IFCD_OPC_JUMP2, IFCD_OPC_MOVD2};
  logic [7:0] pick [4] = '{IFCD_LIT_LO, IFCD_BIT_LO, IFCD_MEM_LO, IFCD_DSP_LO};
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  ifcd_pmem_model ifcd_pmem_model_inst (.sys_clk_i(sys_clk_i),
    .fetch_word_o(fetch_word_i), .fetch_valid_o(fetch_valid_i));
  ifcd_decoder ifcd_decoder_inst (.sys_clk_i, .rst_i, .fetch_word_i,
    .fetch_valid_i, .cond_true_i, .skip_taken_i, .dec_valid_o, .opcode_o,
    .category_o, .two_word_o, .span_o, .nop_o, .flush_o, .cycles_o,
    .base_source_reg_o, .second_source_reg_o, .result_dest_reg_o,
    .src_mode_o, .dst_mode_o(), .dst_present_o, .literal_o,
    .bit_indirect_o, .acc_b_o, .x_prefetch_o, .y_prefetch_o(),
    .x_pf_dest_o(), .y_pf_dest_o(), .acc_wb_o(), .shift_count_register_o(),
    .shift_by_reg_o, .prog_addr_o, .table_mode_o(), .format_err_o);
  function automatic logic [3:0] exp_dst(input logic [23:0] x);
    return (x[23:20] == 4'hB && !x[13]) ? IFCD_DEFAULT_WORKING_REGISTER_IDX : x[10:7];
  endfunction
  function automatic logic [2:0] exp_cat(input logic [7:0] o);
    case (o[7:4])
      4'h2: return 3'h2;
      4'hA: return 3'h1;
      4'hC: return 3'h3;
      4'hB: return 3'h0;
      default: return 3'h4;
    endcase
  endfunction
  task automatic send(input logic [23:0] x, input logic c, input logic s);
    cond_true_i = c;
    skip_taken_i = s;
    ifcd_pmem_model_inst.put(x);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h14967C14));
    repeat (3) @(negedge sys_clk_i);
    rst_i = 1'b0;
    `CHK("category", 3'h4, category_o)
    `CHK("cycles", IFCD_CYC_ONE, cycles_o)
    $display("test 1 done");
    for (int i = 0; i < 3; i++) begin
      w = {dwop[i], 16'($urandom)};
      w2 = {8'h00, 16'($urandom)};
      send(w, 1'b0, 1'b0);
      send(w2, 1'b0, 1'b0);
      `CHK("dvalid", 1'b1, dec_valid_o)
      `CHK("twoword", 1'b1, two_word_o)
      `CHK("cycles", IFCD_CYC_TWO, cycles_o)
      `CHK("span", {w, w2}, span_o)
      `CHK("addr", {w2[6:0], w[15:0]}, prog_addr_o)
      `CHK("flush", dwop[i] != IFCD_OPC_MOVD2, flush_o)
      send({IFCD_LIT_LO, 16'($urandom)}, 1'b0, 1'b0);
      `CHK("drop", dwop[i] != IFCD_OPC_MOVD2, nop_o)
    end
    $display("test 2 done");
    for (int i = 0; i < 24; i++) begin
      w = {pick[i % 4] | 8'($urandom % 16), 16'($urandom)};
      send(w, 1'b0, 1'b0);
      `CHK("opcode", w[23:16], opcode_o)
      `CHK("category", exp_cat(w[23:16]), category_o)
      `CHK("cycles", IFCD_CYC_ONE, cycles_o)
      `CHK("twoword", 1'b0, two_word_o)
      `CHK("base", w[14:11], base_source_reg_o)
      `CHK("second", w[3:0], second_source_reg_o)
      `CHK("dest", exp_dst(w), result_dest_reg_o)
      `CHK("literal", w[15:0], literal_o)
      `CHK("dstp", (w[23:20] == 4'h2) ? (w[14:11] != w[10:7]) : 1'b1,
           dst_present_o)
      `CHK("srcmode", w[6:4], src_mode_o)
      `CHK("bitind", w[23:20] == 4'hA && w[15], bit_indirect_o)
      `CHK("accb", w[15], acc_b_o)
      `CHK("xpf", (w[23:19] == 5'h18) ? w[5:2] : 4'h0, x_prefetch_o)
      `CHK("shreg", w[23:19] == 5'h19 && !w[13], shift_by_reg_o)
    end
    $display("test 3 done");
    for (int i = 0; i < 3; i++) begin
      // skip taken, condition true, then a fixed two-cycle table read
      w = {i == 2 ? IFCD_OPC_TBLRD : i ? IFCD_OPC_CJREL : IFCD_OPC_SKIP,
           16'($urandom)};
      send(w, i == 1, i == 0);
      `CHK("cycles", IFCD_CYC_TWO, cycles_o)
      `CHK("flowflush", 1'b1, flush_o)
      send({IFCD_LIT_LO, 16'($urandom)}, 1'b0, 1'b0);
      `CHK("skipped", 1'b1, nop_o)
    end
    send({IFCD_OPC_SKIP, 16'($urandom)}, 1'b0, 1'b1);
    send({IFCD_OPC_JUMP2, 16'($urandom)}, 1'b0, 1'b0);
    `CHK("skip2a", 1'b1, nop_o)
    send({8'h00, 16'($urandom)}, 1'b0, 1'b0);
    `CHK("skip2b", 1'b1, nop_o)
    $display("test 4 done");
    send({8'h00, 16'($urandom)}, 1'b0, 1'b0);
    `CHK("alone", 1'b1, nop_o)
    send({IFCD_OPC_MOVD2, 16'($urandom)}, 1'b0, 1'b0);
    send({8'h5A, 16'($urandom)}, 1'b0, 1'b0);
    `CHK("bad2nd", 1'b1, nop_o)
    `CHK("fmterr", 1'b1, format_err_o)
    $display("test 5 done");
    results();
  end
endmodule // instruction_format_cycle_decoder_tb
`default_nettype wire
